// ### rtl/pcr_map.svh
/*
  register offsets, field positions, reset values and clock figures of the
  power control register bank. assumes it is included by bare name.
*/
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// serial bus slave address; a board choice, value arbitrary
`define PCR_DEV_ADDR 7'h48

`define PCR_REG_CTL 8'h03
`define PCR_REG_OP 8'h04
`define PCR_REG_EN 8'h05

// regulator control register fields
`define PCR_CTL_ON_HI 7
`define PCR_CTL_ON_LO 5
`define PCR_CTL_ALL 4
`define PCR_CTL_GOOD_HI 3
`define PCR_CTL_GOOD_LO 1
`define PCR_CTL_GATE 0
`define PCR_CTL_RESET 8'h00

// operation control register fields
`define PCR_OP_LOW_SEL 6
`define PCR_OP_HIGH_SEL 5
`define PCR_OP_AC 4
`define PCR_OP_MASK_HI 3
`define PCR_OP_MASK_LO 1
`define PCR_OP_THERMAL 0

// enable pin control register fields
`define PCR_EN_OUT_SEL 1
`define PCR_EN_LEVEL 0

// clock figures in hertz, then sync clock divide ratios
`define PCR_CLK_HZ 20000000
`define PCR_SW_HZ 3000000
`define PCR_HZ_STEP 100000
`define PCR_DIV_LOW 3
`define PCR_DIV_HIGH 6

`endif

// ### rtl/pcr_pkg.sv
/*
  types shared by the power control register bank modules.
  assumes nothing of its surroundings.
*/
package pcr_pkg;

  typedef enum logic [2:0] {
    PCR_ST_IDLE = 3'b000,
    PCR_ST_ADDR = 3'b001,
    PCR_ST_PTR = 3'b010,
    PCR_ST_WDAT = 3'b011,
    PCR_ST_ACK = 3'b100,
    PCR_ST_RDAT = 3'b101,
    PCR_ST_RACK = 3'b110
  } pcr_i2c_st_type;

endpackage

// ### rtl/pcr_reg_if.sv
/*
  register access carrier between the serial slave and the register bank.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface pcr_reg_if;
  logic wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport host (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// ### rtl/pcr_sw_clk_div.sv
/*
  switching clock tick source: internal rate or a divided external sync clock.
  assumes clk_i at 20 MHz and an asynchronous sync clock pin.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcr_map.svh"

module pcr_sw_clk_div
  import pcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sync_clk_i,
  input wire logic low_rate_sel_i,
  input wire logic high_rate_sel_i,
  output logic sw_tick_o
);

  localparam logic [7:0] ACC_INC = 8'(`PCR_SW_HZ / `PCR_HZ_STEP);
  localparam logic [7:0] ACC_MOD = 8'(`PCR_CLK_HZ / `PCR_HZ_STEP);

  logic sync_meta_ff;
  logic sync_s_ff;
  logic sync_d_ff;
  logic [7:0] acc_ff;
  logic [2:0] edge_cnt_ff;
  logic ext_mode;
  logic [2:0] ext_div;
  logic [7:0] nxt_acc;

  // both selects set is not a legal setting; fall back to the internal rate [R09]
  assign ext_mode = low_rate_sel_i ^ high_rate_sel_i;
  assign ext_div = high_rate_sel_i ? 3'(`PCR_DIV_HIGH) : 3'(`PCR_DIV_LOW);
  assign nxt_acc = acc_ff + ACC_INC;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_meta_ff <= 1'b0;
      sync_s_ff <= 1'b0;
      sync_d_ff <= 1'b0;
    end else begin
      sync_meta_ff <= sync_clk_i;
      sync_s_ff <= sync_meta_ff;
      sync_d_ff <= sync_s_ff;
    end
  end

  // limitation: the 19.2 MHz sync rate is above half of clk_i, so its edges
  // alias here; a faster sampling clock is needed for that mode in silicon
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc_ff <= 8'h00;
      edge_cnt_ff <= 3'h0;
      sw_tick_o <= 1'b0;
    end else if (ext_mode) begin
      acc_ff <= 8'h00;
      sw_tick_o <= 1'b0;
      if (sync_s_ff && !sync_d_ff) begin
        if (edge_cnt_ff >= ext_div - 3'h1) begin // [R07] [R08]
          edge_cnt_ff <= 3'h0;
          sw_tick_o <= 1'b1;
        end else begin
          edge_cnt_ff <= edge_cnt_ff + 3'h1;
        end
      end
    end else begin
      edge_cnt_ff <= 3'h0;
      // fractional accumulator gives 3 ticks per 20 clocks [R10]
      if (nxt_acc >= ACC_MOD) begin
        acc_ff <= nxt_acc - ACC_MOD;
        sw_tick_o <= 1'b1;
      end else begin
        acc_ff <= nxt_acc;
        sw_tick_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### rtl/pcr_i2c_slave.sv
/*
  two-wire serial register slave: device address, register pointer, data
  bytes with auto increment; reads from the current pointer.
  assumes scl/sda are pins well slower than clk_i (up to 400 kHz).
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcr_map.svh"

module pcr_i2c_slave
  import pcr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `PCR_DEV_ADDR
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_n_o,
  pcr_reg_if.host rif
);

  logic [1:0] pin_meta_ff;
  logic [1:0] pin_s_ff;
  logic [1:0] pin_d_ff;
  pcr_i2c_st_type st_ff;
  pcr_i2c_st_type after_ff;
  logic [7:0] shreg_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] ptr_ff;
  logic wr_stb_ff;
  logic [7:0] wdata_ff;
  logic scl_s;
  logic sda_s;
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;
  logic byte_done;

  assign scl_s = pin_s_ff[1];
  assign sda_s = pin_s_ff[0];
  assign bus_start = scl_s && pin_d_ff[1] && pin_d_ff[0] && !sda_s;
  assign bus_stop = scl_s && pin_d_ff[1] && !pin_d_ff[0] && sda_s;
  assign scl_rise = scl_s && !pin_d_ff[1];
  assign scl_fall = !scl_s && pin_d_ff[1];
  assign byte_done = (bitcnt_ff == 4'h8);
  assign rif.wr_stb = wr_stb_ff;
  assign rif.wdata = wdata_ff;
  assign rif.addr = ptr_ff;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_meta_ff <= 2'h3;
      pin_s_ff <= 2'h3;
      pin_d_ff <= 2'h3;
    end else begin
      pin_meta_ff <= {scl_i, sda_i};
      pin_s_ff <= pin_meta_ff;
      pin_d_ff <= pin_s_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff <= PCR_ST_IDLE;
      after_ff <= PCR_ST_IDLE;
      shreg_ff <= 8'h00;
      bitcnt_ff <= 4'h0;
      ptr_ff <= 8'h00;
      sda_oe_n_o <= 1'b1;
      wr_stb_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      wr_stb_ff <= 1'b0;
      // pointer moves one cycle after the write so the strobe sees its address
      if (wr_stb_ff) begin
        ptr_ff <= ptr_ff + 8'h01;
      end
      if (bus_start) begin
        st_ff <= PCR_ST_ADDR;
        bitcnt_ff <= 4'h0;
        sda_oe_n_o <= 1'b1;
      end else if (bus_stop) begin
        st_ff <= PCR_ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end else if (scl_rise) begin
        unique case (st_ff)
          PCR_ST_ADDR, PCR_ST_PTR, PCR_ST_WDAT: begin
            shreg_ff <= {shreg_ff[6:0], sda_s};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end
          PCR_ST_RDAT: bitcnt_ff <= bitcnt_ff + 4'h1;
          PCR_ST_RACK: begin
            if (sda_s) begin
              st_ff <= PCR_ST_IDLE;
            end else begin
              shreg_ff <= rif.rdata;
              ptr_ff <= ptr_ff + 8'h01;
            end
          end
          PCR_ST_IDLE, PCR_ST_ACK: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (st_ff)
          PCR_ST_ADDR: begin
            if (byte_done && shreg_ff[7:1] == DEV_ADDR) begin
              st_ff <= PCR_ST_ACK;
              sda_oe_n_o <= 1'b0;
              bitcnt_ff <= 4'h0;
              if (shreg_ff[0]) begin
                after_ff <= PCR_ST_RDAT;
                shreg_ff <= rif.rdata;
                ptr_ff <= ptr_ff + 8'h01;
              end else begin
                after_ff <= PCR_ST_PTR;
              end
            end else if (byte_done) begin
              st_ff <= PCR_ST_IDLE;
            end
          end
          PCR_ST_PTR, PCR_ST_WDAT: begin
            if (byte_done) begin
              if (st_ff == PCR_ST_PTR) begin
                ptr_ff <= shreg_ff;
              end else begin
                wr_stb_ff <= 1'b1;
                wdata_ff <= shreg_ff;
              end
              st_ff <= PCR_ST_ACK;
              after_ff <= PCR_ST_WDAT;
              sda_oe_n_o <= 1'b0;
              bitcnt_ff <= 4'h0;
            end
          end
          PCR_ST_ACK: begin
            st_ff <= after_ff;
            if (after_ff == PCR_ST_RDAT) begin
              sda_oe_n_o <= shreg_ff[7];
              shreg_ff <= {shreg_ff[6:0], 1'b0};
            end else begin
              sda_oe_n_o <= 1'b1;
            end
          end
          PCR_ST_RDAT: begin
            if (byte_done) begin
              sda_oe_n_o <= 1'b1;
              st_ff <= PCR_ST_RACK;
            end else begin
              sda_oe_n_o <= shreg_ff[7];
              shreg_ff <= {shreg_ff[6:0], 1'b0};
            end
          end
          PCR_ST_RACK: begin
            st_ff <= PCR_ST_RDAT;
            bitcnt_ff <= 4'h0;
            sda_oe_n_o <= shreg_ff[7];
            shreg_ff <= {shreg_ff[6:0], 1'b0};
          end
          PCR_ST_IDLE: begin
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### rtl/pcr_power_regs.sv
/*
  power control register bank: regulator enables, power-good status,
  camera shutdown gating, sync clock selection, thermal latch, enable pin.
  assumes analog comparators for power good and thermal trip, a power-on
  reset on sys_rst_i, and fuse mask levels stable while reset is held.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcr_map.svh"

// Contract
// R01: bits 7,6,5 switch each regulator on
// R02: sequence-all bit works only with individual bits clear
// R03: bits 3,2,1 read back power-good status
// R04: gate bit set: shutdown output follows power good; code also needs a regulator enable set and the thermal latch clear
// R05: gate clear, pin low: shutdown output low
// R06: pin high acts as gate bit set
// R07: low-rate sync select divides external clock by 3
// R08: high-rate sync select divides external clock by 6
// R09: host never sets both sync selects
// R10: no sync select: internal 3 MHz switching clock
// R11: bit 4 selects ac or dc sync path
// R12: sync selects frozen while switching regulators run
// R13: fuse-loaded masks drop a regulator from power good
// R14: bit 0 latches a thermal trip event
// R15: thermal latch set blocks all regulator activation
// R16: enable pin control bit 1 picks pin output mode
// R17: enable pin control bit 0 sets output level
// R18: shutdown high only with good and pin/gate
// R19: individual enables disable automatic sequencing
// R20: power good high at 80 percent of target
// R21: reserved bits ignore writes, read zero
module pcr_power_regs
  import pcr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `PCR_DEV_ADDR
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic en_pin_i,
  output logic en_pin_o,
  output logic en_pin_oe_n_o,
  input wire logic sync_clk_i,
  input wire logic [2:0] fuse_mask_i,
  input wire logic first_buck_good_i,
  input wire logic second_buck_good_i,
  input wire logic linear_reg_good_i,
  input wire logic thermal_event_i,
  output logic first_buck_on_o,
  output logic second_buck_on_o,
  output logic linear_reg_on_o,
  output logic seq_all_on_o,
  output logic ext_clk_ac_path_o,
  output logic sw_clk_tick_o,
  output logic camera_shutdown_n_o
);

  pcr_reg_if rif ();

  logic [4:0] in_meta_ff;
  logic [4:0] in_s_ff;
  logic [2:0] reg_on_ff;
  logic seq_all_ff;
  logic shutdown_out_gate_ff;
  logic ext_clk_low_rate_sel_ff;
  logic ext_clk_high_rate_sel_ff;
  logic ext_clk_ac_path_ff;
  logic [2:0] good_mask_ff;
  logic thermal_trip_latch_ff;
  logic enable_pin_output_sel_ff;
  logic gpio_out_level_ff;
  logic [2:0] good_s;
  logic thermal_s;
  logic en_input;
  logic power_ok;
  logic any_enable;
  logic seq_request;
  logic sw_running;
  logic wr_ctl;
  logic wr_op;
  logic wr_en;
  logic [7:0] rdata_c;

  pcr_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_n_o(sda_oe_n_o),
    .rif(rif)
  );

  pcr_sw_clk_div u_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sync_clk_i(sync_clk_i),
    .low_rate_sel_i(ext_clk_low_rate_sel_ff),
    .high_rate_sel_i(ext_clk_high_rate_sel_ff),
    .sw_tick_o(sw_clk_tick_o)
  );

  // open drain: the data pin is only ever pulled low
  assign sda_o = 1'b0;

  // power good arrives from the 80 percent comparators, so only synchronised here [R20]
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      in_meta_ff <= 5'h00;
      in_s_ff <= 5'h00;
    end else begin
      in_meta_ff <= {thermal_event_i, en_pin_i, first_buck_good_i,
                     second_buck_good_i, linear_reg_good_i};
      in_s_ff <= in_meta_ff;
    end
  end

  assign good_s = in_s_ff[2:0];
  assign thermal_s = in_s_ff[4];
  // the enable function is ignored while the pin is an output [R16]
  assign en_input = in_s_ff[3] && !enable_pin_output_sel_ff;
  assign power_ok = &(good_s | good_mask_ff); // [R13]
  assign any_enable = ((|reg_on_ff) || seq_all_ff) && !thermal_trip_latch_ff;
  // individual enables hand timing to the host and stop the sequencer [R02] [R19]
  assign seq_request = (seq_all_ff || en_input) && !(|reg_on_ff);
  assign sw_running = first_buck_on_o || second_buck_on_o || seq_all_on_o;
  assign wr_ctl = rif.wr_stb && (rif.addr == `PCR_REG_CTL);
  assign wr_op = rif.wr_stb && (rif.addr == `PCR_REG_OP);
  assign wr_en = rif.wr_stb && (rif.addr == `PCR_REG_EN);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_on_ff <= 3'h0;
      seq_all_ff <= 1'b0;
      shutdown_out_gate_ff <= 1'b0;
    end else if (wr_ctl) begin
      reg_on_ff <= rif.wdata[`PCR_CTL_ON_HI:`PCR_CTL_ON_LO]; // [R01]
      seq_all_ff <= rif.wdata[`PCR_CTL_ALL];
      shutdown_out_gate_ff <= rif.wdata[`PCR_CTL_GATE];
    end
  end

  // sync selection only moves while no switching regulator runs [R12]
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_clk_low_rate_sel_ff <= 1'b0;
      ext_clk_high_rate_sel_ff <= 1'b0;
      ext_clk_ac_path_ff <= 1'b0;
    end else if (wr_op && !sw_running) begin
      ext_clk_low_rate_sel_ff <= rif.wdata[`PCR_OP_LOW_SEL]; // [R07]
      ext_clk_high_rate_sel_ff <= rif.wdata[`PCR_OP_HIGH_SEL]; // [R08]
      ext_clk_ac_path_ff <= rif.wdata[`PCR_OP_AC]; // [R11]
    end
  end

  // fuses are loaded while reset is held, then software may override
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      good_mask_ff <= fuse_mask_i; // [R13]
    end else if (wr_op) begin
      good_mask_ff <= rif.wdata[`PCR_OP_MASK_HI:`PCR_OP_MASK_LO];
    end
  end

  // a trip in the clearing cycle wins, so no event is lost [R14]
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      thermal_trip_latch_ff <= 1'b0;
    end else if (thermal_s) begin
      thermal_trip_latch_ff <= 1'b1;
    end else if (wr_op && !rif.wdata[`PCR_OP_THERMAL]) begin
      thermal_trip_latch_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      enable_pin_output_sel_ff <= 1'b0;
      gpio_out_level_ff <= 1'b0;
    end else if (wr_en) begin
      enable_pin_output_sel_ff <= rif.wdata[`PCR_EN_OUT_SEL];
      gpio_out_level_ff <= rif.wdata[`PCR_EN_LEVEL];
    end
  end

  // unmapped and reserved bits read zero, writes to them are dropped [R21]
  always_comb begin
    rdata_c = 8'h00;
    unique case (rif.addr)
      `PCR_REG_CTL: begin
        rdata_c = {reg_on_ff, seq_all_ff, good_s, shutdown_out_gate_ff}; // [R03]
      end
      `PCR_REG_OP: begin
        rdata_c = {1'b0, ext_clk_low_rate_sel_ff, ext_clk_high_rate_sel_ff,
                   ext_clk_ac_path_ff, good_mask_ff, thermal_trip_latch_ff};
      end
      `PCR_REG_EN: begin
        rdata_c = {6'h00, enable_pin_output_sel_ff, gpio_out_level_ff};
      end
      default: begin
        rdata_c = 8'h00;
      end
    endcase
  end

  assign rif.rdata = rdata_c;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      first_buck_on_o <= 1'b0;
      second_buck_on_o <= 1'b0;
      linear_reg_on_o <= 1'b0;
      seq_all_on_o <= 1'b0;
    end else begin
      // the latched trip holds every regulator off [R15]
      first_buck_on_o <= reg_on_ff[2] && !thermal_trip_latch_ff; // [R01]
      second_buck_on_o <= reg_on_ff[1] && !thermal_trip_latch_ff;
      linear_reg_on_o <= reg_on_ff[0] && !thermal_trip_latch_ff;
      seq_all_on_o <= seq_request && !thermal_trip_latch_ff; // [R02]
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      camera_shutdown_n_o <= 1'b0;
      ext_clk_ac_path_o <= 1'b0;
      en_pin_o <= 1'b0;
      en_pin_oe_n_o <= 1'b1;
    end else begin
      // pin high overrides the gate bit; gate needs an enabled regulator [R04] [R05] [R06] [R18]
      camera_shutdown_n_o <= power_ok && (en_input || (shutdown_out_gate_ff && any_enable));
      ext_clk_ac_path_o <= ext_clk_ac_path_ff; // [R11]
      en_pin_o <= gpio_out_level_ff; // [R17]
      en_pin_oe_n_o <= !enable_pin_output_sel_ff; // [R16]
    end
  end

  chk_indiv_enable_on: assert property ( // [R01]
    @(posedge clk_i) disable iff (sys_rst_i)
    (reg_on_ff[2] && !thermal_trip_latch_ff) |=> first_buck_on_o)
    else $error("first buck not switched on by its enable bit");

  chk_seq_all_gate: assert property ( // [R02]
    @(posedge clk_i) disable iff (sys_rst_i)
    seq_all_on_o |-> $past(reg_on_ff) == 3'h0)
    else $error("sequencer ran with an individual enable set");

  chk_good_readback: assert property ( // [R03]
    @(posedge clk_i) disable iff (sys_rst_i)
    (rif.addr == `PCR_REG_CTL) |-> rif.rdata[3:1] == $past({first_buck_good_i,
                                   second_buck_good_i, linear_reg_good_i}, 2))
    else $error("power good bits do not read back status");

  chk_gate_follows_good: assert property ( // [R04]
    @(posedge clk_i) disable iff (sys_rst_i)
    (shutdown_out_gate_ff && any_enable && power_ok) |=> camera_shutdown_n_o)
    else $error("shutdown output not released with gate and good");

  chk_gate_low_hold: assert property ( // [R05]
    @(posedge clk_i) disable iff (sys_rst_i)
    (!shutdown_out_gate_ff && !en_input) |=> !camera_shutdown_n_o)
    else $error("shutdown output high with gate and pin low");

  chk_pin_override: assert property ( // [R06]
    @(posedge clk_i) disable iff (sys_rst_i)
    en_input |=> camera_shutdown_n_o == $past(power_ok))
    else $error("shutdown output ignores power good with pin high");

  chk_sync_sel_frozen: assert property ( // [R12]
    @(posedge clk_i) disable iff (sys_rst_i)
    sw_running |=> $stable({ext_clk_low_rate_sel_ff, ext_clk_high_rate_sel_ff,
                            ext_clk_ac_path_ff}))
    else $error("sync selection changed while switching");

  chk_thermal_latch: assert property ( // [R14]
    @(posedge clk_i) disable iff (sys_rst_i)
    thermal_s |=> thermal_trip_latch_ff ##1 (thermal_trip_latch_ff || $past(wr_op)))
    else $error("thermal trip not latched");

  chk_thermal_block: assert property ( // [R15]
    @(posedge clk_i) disable iff (sys_rst_i)
    thermal_trip_latch_ff |=> !(first_buck_on_o || second_buck_on_o ||
                                linear_reg_on_o || seq_all_on_o))
    else $error("regulator active with thermal latch set");

  chk_gpio_drive: assert property ( // [R17]
    @(posedge clk_i) disable iff (sys_rst_i)
    enable_pin_output_sel_ff |=> !en_pin_oe_n_o && en_pin_o == $past(gpio_out_level_ff))
    else $error("enable pin not driven at programmed level");

  chk_reserved_zero: assert property ( // [R21]
    @(posedge clk_i) disable iff (sys_rst_i)
    (rif.addr == `PCR_REG_EN) |-> rif.rdata[7:2] == 6'h00)
    else $error("reserved enable pin bits read nonzero");

endmodule

`default_nettype wire

// ### verif/pcr_host_model.sv
/*
  host model: two-wire bus master with register write and read tasks.
  assumes a pull-up on sda and that the bench resolves the wire level.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcr_map.svh"

module pcr_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  int nacks = 0;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // quarter bit time, far above the slave's three-cycle pin latency
  task automatic q();
    repeat (15) @(posedge clk_i);
    #1;
  endtask

  // also serves as repeated start when scl is low
  task automatic start();
    sda_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b0;
    q();
    scl_o = 1'b0;
  endtask

  task automatic stop();
    q();
    sda_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b1;
    q();
  endtask

  task automatic bit_x(input logic b, output logic r);
    q();
    sda_o = b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_i;
    q();
    scl_o = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_x(w[i], r[i]);
    end
  endtask

  task automatic send(input logic [7:0] w);
    logic [7:0] r;
    logic a;
    xfer(w, r);
    bit_x(1'b1, a);
    if (a !== 1'b0) begin
      nacks++;
    end
  endtask

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    start();
    send({`PCR_DEV_ADDR, 1'b0});
    send(ra);
    send(d);
    stop();
  endtask

  task automatic rd(input logic [7:0] ra, output logic [7:0] d);
    logic a;
    start();
    send({`PCR_DEV_ADDR, 1'b0});
    send(ra);
    start();
    send({`PCR_DEV_ADDR, 1'b1});
    xfer(8'hff, d);
    bit_x(1'b1, a);
    stop();
  endtask
endmodule

`default_nettype wire

// ### verif/power_control_register_bank_tb_top.sv
/*
  testbench of the power control register bank, driven through the host model.
  assumes the rtl files and the host model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module power_control_register_bank_tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic tb_en = 1'b0;
  logic therm = 1'b0;
  logic [1:0] sc = 2'h0;
  logic [2:0] fuse = 3'h5;
  logic [2:0] good = 3'h0;
  logic scl, hsda, sda_oe_n, sda_d, en_o, en_oe_n, on1, on2, on3, seq, ac, tick, cam;
  logic [7:0] rv;
  int errors = 0;
  int checked = 0;
  int n;
  // open drain with pull-up; the enable pin is ours only while the device floats it
  wire logic sda_w = hsda & (sda_oe_n | sda_d);
  wire logic en_w = en_oe_n ? tb_en : en_o;

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) sc <= #1 sc + 2'h1;

  pcr_host_model host_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda));

  pcr_power_regs dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n), .en_pin_i(en_w),
    .en_pin_o(en_o), .en_pin_oe_n_o(en_oe_n), .sync_clk_i(sc[1]),
    .fuse_mask_i(fuse), .first_buck_good_i(good[2]), .second_buck_good_i(good[1]),
    .linear_reg_good_i(good[0]), .thermal_event_i(therm), .first_buck_on_o(on1),
    .second_buck_on_o(on2), .linear_reg_on_o(on3), .seq_all_on_o(seq),
    .ext_clk_ac_path_o(ac), .sw_clk_tick_o(tick), .camera_shutdown_n_o(cam));

  task automatic conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic w(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
    host_u.rd(a, rv);
    chk(rv, e, m);
  endtask

  // tick spacing depends on divider phase, so one tick either way is allowed
  task automatic near(input int c, input int e, input string m);
    int k;
    k = 0;
    repeat (c) begin
      w(1);
      if (tick === 1'b1) begin
        k++;
      end
    end
    chk({7'h0, k >= e - 1 && k <= e + 1}, 8'h01, m);
  endtask

  initial begin
    repeat (90000) @(posedge clk_i);
    errors++;
    conclude();
  end

  initial begin
    w(3);
    sys_rst_i = 1'b0;
    w(5);
    rchk(8'h03, 8'h00, "ctl reset");
    rchk(8'h04, 8'h0a, "op reset");
    rchk(8'h05, 8'h00, "en reset");
    rchk(8'h01, 8'h00, "unmapped");
    chk({7'h0, en_oe_n}, 8'h01, "pin hiz");
    near(200, 30, "int tick");
    $display("test reset done");
    good = 3'h2;
    host_u.wr(8'h03, 8'he1);
    chk({5'h0, on1, on2, on3}, 8'h07, "on");
    chk({7'h0, cam}, 8'h01, "cam gate");
    rchk(8'h03, 8'he5, "good read");
    good = 3'h0;
    w(6);
    chk({7'h0, cam}, 8'h00, "cam unmasked");
    good = 3'h2;
    host_u.wr(8'h04, 8'h5a);
    rchk(8'h04, 8'h0a, "sync frozen");
    host_u.wr(8'h03, 8'he0);
    chk({7'h0, cam}, 8'h00, "cam held");
    tb_en = 1'b1;
    w(6);
    chk({7'h0, cam}, 8'h01, "cam pin");
    tb_en = 1'b0;
    host_u.wr(8'h03, 8'hf0);
    chk({4'h0, on1, on2, on3, seq}, 8'h0e, "no seq");
    host_u.wr(8'h03, 8'h10);
    chk({4'h0, on1, on2, on3, seq}, 8'h01, "seq all");
    // gate set but nothing enabled and pin low: output must stay low
    host_u.wr(8'h03, 8'h01);
    chk({7'h0, cam}, 8'h00, "cam off");
    $display("test regulators done");
    // one rate select at a time, written only with the regulators off
    host_u.wr(8'h04, 8'h5a);
    chk({7'h0, ac}, 8'h01, "ac path");
    near(240, 20, "low tick");
    host_u.wr(8'h04, 8'h2a);
    chk({7'h0, ac}, 8'h00, "dc path");
    near(240, 10, "high tick");
    host_u.wr(8'h04, 8'h0a);
    $display("test sync done");
    therm = 1'b1;
    w(6);
    therm = 1'b0;
    rchk(8'h04, 8'h0b, "trip");
    host_u.wr(8'h03, 8'he0);
    chk({5'h0, on1, on2, on3}, 8'h00, "inhibit");
    host_u.wr(8'h04, 8'h0a);
    chk({5'h0, on1, on2, on3}, 8'h07, "released");
    host_u.wr(8'h03, 8'h00);
    $display("test thermal done");
    host_u.wr(8'h05, 8'h03);
    chk({6'h0, en_oe_n, en_o}, 8'h01, "gpio high");
    tb_en = 1'b1;
    w(6);
    chk({7'h0, seq}, 8'h00, "pin ignored");
    host_u.wr(8'h05, 8'hfe);
    chk({6'h0, en_oe_n, en_o}, 8'h00, "gpio low");
    rchk(8'h05, 8'h02, "en reserved");
    chk({7'h0, host_u.nacks == 0}, 8'h01, "acks");
    $display("test enable pin done");
    conclude();
  end
endmodule

`default_nettype wire
